// ===== include/brf_defines.svh
// constants of the banked register file: address map, pointer fields, vector area
// assumes inclusion by bare name from the package and the design files
`ifndef BRF_DEFINES_SVH
`define BRF_DEFINES_SVH
`define BRF_PORT_LAST 8'h03
`define BRF_GPR_FIRST 8'h04
`define BRF_GPR_LAST 8'hEF
`define BRF_CTL_FIRST 8'hF0
`define BRF_GROUP_E 4'hE
`define BRF_RP_ADDR 8'hFD
`define BRF_RP_RESET 8'h00
`define BRF_VEC_BYTES 12
`define BRF_VEC_COUNT 6
`endif

// ===== include/brf_pkg.sv
// types of the banked register file: access request and answer carriers
// assumes the defines header is on the include path
package brf_pkg;
  `include "brf_defines.svh"
  typedef enum logic [1:0] {
    BRF_MODE_DIRECT,
    BRF_MODE_INDIRECT,
    BRF_MODE_WORKING
  } brf_mode_t;
  typedef struct packed {
    logic valid;
    logic write;
    brf_mode_t mode;
    logic [7:0] addr;
    logic [7:0] wdata;
  } brf_req_t;
  typedef struct packed {
    logic valid;
    logic refused;
    logic [7:0] rdata;
  } brf_rsp_t;
endpackage

// ===== rtl/brf_mem.sv
// byte-wide storage for the register file, registered read data
// assumes one access per cycle from the owning register file
`timescale 1ns/10ps
module brf_mem #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // access
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem_reg [DEPTH];

  // storage write, only the addressed byte changes
  always_ff @(posedge clk) begin
    if (we) begin
      mem_reg[addr] <= wdata;
    end
  end

  // read data registered; write-through so a write answers its own value
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= we ? wdata : mem_reg[addr];
    end
  end
endmodule

// ===== rtl/brf_regfile.sv
// bank 0 register file with working-group pointer and expanded bank select
// assumes the execution core issues at most one access per cycle, synchronous inputs
`timescale 1ns/10ps
`include "brf_defines.svh"
module brf_regfile #(
  parameter int VEC_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // access from the execution core
  input brf_pkg::brf_req_t req,
  output brf_pkg::brf_rsp_t rsp,
  // decoded region of the last accepted access
  output logic hit_port,
  output logic hit_gpr,
  output logic hit_ctl,
  output logic [7:0] eff_addr,
  // pointer state
  output logic [7:0] working_group_pointer,
  output logic [3:0] expanded_bank_space,
  // vector fetch from program memory view
  input wire logic [2:0] vec_index,
  input wire logic [7:0] vec_byte_in,
  input wire logic vec_byte_load,
  input wire logic [3:0] vec_byte_addr,
  output logic [VEC_W-1:0] vec_out
);
  import brf_pkg::*;

  logic [7:0] addr_eff;
  logic refuse;
  logic do_acc;
  logic we;
  logic [7:0] rdata_mem;
  logic rp_hit;
  logic [7:0] rp_reg;
  logic [7:0] vec_reg [`BRF_VEC_BYTES];
  logic pend_reg;
  logic pend_refused_reg;
  logic pend_rp_reg;

  // effective address: working mode relocates by pointer group
  always_comb begin
    addr_eff = req.addr;
    if (req.mode == BRF_MODE_WORKING) begin
      addr_eff = {rp_reg[7:4], req.addr[3:0]};
    end
  end

  // direct access to group E refused
  assign refuse = (req.mode == BRF_MODE_DIRECT) && (req.addr[7:4] == `BRF_GROUP_E);
  assign do_acc = req.valid && !refuse;
  assign we = do_acc && req.write;
  assign rp_hit = (addr_eff == `BRF_RP_ADDR);

  brf_mem #(
    .DEPTH(256),
    .AW(8)
  ) u_mem (
    .clk(clk),
    .resetn(resetn),
    .we(we),
    .addr(addr_eff),
    .wdata(req.wdata),
    .rdata(rdata_mem)
  );

  // pointer register written at its control address
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rp_reg <= `BRF_RP_RESET;
    end else if (we && rp_hit) begin
      rp_reg <= req.wdata;
    end
  end

  assign working_group_pointer = rp_reg;
  assign expanded_bank_space = rp_reg[3:0];

  // answer one cycle after any accepted or refused request
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pend_reg <= 1'b0;
      pend_refused_reg <= 1'b0;
      pend_rp_reg <= 1'b0;
    end else begin
      pend_reg <= req.valid;
      pend_refused_reg <= req.valid && refuse;
      pend_rp_reg <= do_acc && rp_hit;
    end
  end

  // region decode held from the last accepted access
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hit_port <= 1'b0;
      hit_gpr <= 1'b0;
      hit_ctl <= 1'b0;
      eff_addr <= 8'h00;
    end else if (do_acc) begin
      hit_port <= (addr_eff <= `BRF_PORT_LAST);
      hit_gpr <= (addr_eff >= `BRF_GPR_FIRST) && (addr_eff <= `BRF_GPR_LAST);
      hit_ctl <= (addr_eff >= `BRF_CTL_FIRST);
      eff_addr <= addr_eff;
    end
  end

  // answer: refused reads give zero; pointer read shows live pointer
  always_comb begin
    rsp.valid = pend_reg;
    rsp.refused = pend_refused_reg;
    rsp.rdata = pend_refused_reg ? 8'h00 : (pend_rp_reg ? rp_reg : rdata_mem);
  end

  // vector area, twelve bytes loaded from program memory
  always_ff @(posedge clk) begin
    if (vec_byte_load && (vec_byte_addr < 4'(`BRF_VEC_BYTES))) begin
      vec_reg[vec_byte_addr] <= vec_byte_in;
    end
  end

  // six 16-bit vectors, high byte first
  always_ff @(posedge clk) begin
    if (!resetn) begin
      vec_out <= '0;
    end else if (vec_index < 3'(`BRF_VEC_COUNT)) begin
      vec_out <= {vec_reg[{vec_index, 1'b0}], vec_reg[{vec_index, 1'b1}]};
    end else begin
      vec_out <= '0;
    end
  end

  // shadow of written bytes for read-back checks
  logic [7:0] shadow_reg [256];
  logic [255:0] shadow_ok_reg;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      shadow_ok_reg <= '0;
    end else if (we && !rp_hit) begin
      shadow_ok_reg[addr_eff] <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (we) begin
      shadow_reg[addr_eff] <= req.wdata;
    end
  end
  logic [7:0] chk_addr_reg;
  logic chk_rd_reg;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      chk_rd_reg <= 1'b0;
      chk_addr_reg <= 8'h00;
    end else begin
      chk_rd_reg <= do_acc && !req.write && !rp_hit && shadow_ok_reg[addr_eff];
      chk_addr_reg <= addr_eff;
    end
  end

  // assertions
  direct_e_refused_a: assert property (@(posedge clk) disable iff (!resetn)
    req.valid && req.mode == BRF_MODE_DIRECT && req.addr[7:4] == 4'hE
    |=> rsp.valid && rsp.refused && rsp.rdata == 8'h00)
    else $error("direct access to group E not refused");
  working_addr_a: assert property (@(posedge clk) disable iff (!resetn)
    req.valid && req.mode == BRF_MODE_WORKING
    |=> eff_addr == {$past(rp_reg[7:4]), $past(req.addr[3:0])})
    else $error("working address not relocated by pointer");
  group_size_a: assert property (@(posedge clk) disable iff (!resetn)
    req.valid && req.mode == BRF_MODE_WORKING |=> eff_addr[7:4] == $past(rp_reg[7:4]))
    else $error("working access left its group");
  pointer_split_a: assert property (@(posedge clk) disable iff (!resetn)
    req.valid && req.write && req.mode != BRF_MODE_WORKING && req.addr == 8'hFD
    |=> expanded_bank_space == $past(req.wdata[3:0])
        && working_group_pointer[7:4] == $past(req.wdata[7:4]))
    else $error("pointer nibbles not split");
  region_decode_a: assert property (@(posedge clk) disable iff (!resetn)
    req.valid && req.mode == BRF_MODE_INDIRECT && req.addr >= 8'h04 && req.addr <= 8'hEF
    |=> hit_gpr && !hit_port && !hit_ctl)
    else $error("general register decode wrong");
  ctl_decode_a: assert property (@(posedge clk) disable iff (!resetn)
    req.valid && req.mode == BRF_MODE_INDIRECT && req.addr >= 8'hF0
    |=> hit_ctl && !hit_gpr)
    else $error("control group decode wrong");
  answer_next_a: assert property (@(posedge clk) disable iff (!resetn)
    req.valid |=> rsp.valid)
    else $error("access not answered next cycle");
  readback_a: assert property (@(posedge clk) disable iff (!resetn)
    chk_rd_reg |-> rsp.rdata == shadow_reg[chk_addr_reg])
    else $error("read did not return stored value");
  vector_a: assert property (@(posedge clk) disable iff (!resetn)
    vec_index >= 3'h6 |=> vec_out == '0)
    else $error("vector beyond six not zero");

  working_write_c: cover property (@(posedge clk) disable iff (!resetn)
    req.valid && req.write && req.mode == BRF_MODE_WORKING);
  refused_c: cover property (@(posedge clk) disable iff (!resetn) rsp.refused);
  pointer_write_c: cover property (@(posedge clk) disable iff (!resetn)
    req.valid && req.write && rp_hit && !refuse);
  readback_c: cover property (@(posedge clk) disable iff (!resetn) chk_rd_reg);
endmodule

// ===== test/brf_core_model.sv
// execution core model: issues one register access at a time
// assumes rsp answers one edge after the edge that takes req
`timescale 1ns/10ps
module brf_core_model (
  // clock
  input wire logic clk,
  // register access
  output brf_pkg::brf_req_t req,
  input brf_pkg::brf_rsp_t rsp
);
  import brf_pkg::*;
  initial req = '0;
  // driven at the falling edge, answer read at the next falling edge
  task automatic access(input logic wr, input brf_mode_t md, input logic [7:0] a, d,
      output brf_rsp_t r);
    @(negedge clk);
    req <= '{1'b1, wr, md, a, d};
    @(negedge clk);
    r = rsp;
    req.valid <= 1'b0; // idle cycle between accesses keeps drives apart
  endtask
endmodule

// ===== test/tb_top.sv
// self-checking bench for the banked register file
// assumes the core model drives req; the bench drives reset and vectors
`timescale 1ns/10ps
module tb_top;
  import brf_pkg::*;
  logic clk;
  logic resetn;
  brf_req_t req;
  brf_rsp_t rsp;
  brf_rsp_t r;
  logic hit_port;
  logic hit_gpr;
  logic hit_ctl;
  logic [7:0] eff_addr;
  logic [7:0] ptr;
  logic [3:0] bank;
  logic [2:0] vec_index;
  logic [7:0] vec_byte_in;
  logic vec_byte_load;
  logic [3:0] vec_byte_addr;
  logic [15:0] vec_out;
  int num_errors = 0;
  int tests_run = 0;

  brf_regfile dut (.clk(clk), .resetn(resetn), .req(req), .rsp(rsp),
    .hit_port(hit_port), .hit_gpr(hit_gpr), .hit_ctl(hit_ctl), .eff_addr(eff_addr),
    .working_group_pointer(ptr), .expanded_bank_space(bank), .vec_index(vec_index),
    .vec_byte_in(vec_byte_in), .vec_byte_load(vec_byte_load),
    .vec_byte_addr(vec_byte_addr), .vec_out(vec_out));
  brf_core_model core (.clk(clk), .req(req), .rsp(rsp));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic acc(input logic wr, input brf_mode_t md, input logic [7:0] a, d);
    core.access(wr, md, a, d, r);
    check("rsp valid", r.valid, 1'b1);
  endtask

  task automatic t_reset;
    check("pointer", ptr, 8'h00);
    check("vector", vec_out, 16'h0000);
  endtask

  // written direct, read back indirect, two in the general registers and one in each other region
  task automatic t_decode;
    logic [7:0] a[4] = '{8'h03, 8'h04, 8'hDF, 8'hF0};
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, BRF_MODE_DIRECT, a[i], 8'h5A ^ a[i]);
      acc(1'b0, BRF_MODE_INDIRECT, a[i], 8'h00);
      check("hits", {hit_port, hit_gpr, hit_ctl}, {i == 0, i inside {1, 2}, i == 3});
      check("eff", eff_addr, a[i]);
      check("data", r.rdata, 8'h5A ^ a[i]);
    end
    // later writes elsewhere must leave the first byte alone
    acc(1'b0, BRF_MODE_DIRECT, a[0], 8'h00);
    check("data", r.rdata, 8'h5A ^ a[0]);
  endtask

  task automatic t_pointer;
    acc(1'b1, BRF_MODE_DIRECT, 8'hFD, 8'h7D);
    check("pointer", ptr, 8'h7D);
    check("bank", bank, 4'hD);
    acc(1'b1, BRF_MODE_WORKING, 8'h01, 8'h3C);
    check("eff", eff_addr, 8'h71);
    acc(1'b1, BRF_MODE_WORKING, 8'h0F, 8'hC3);
    check("eff", eff_addr, 8'h7F);
    acc(1'b0, BRF_MODE_DIRECT, 8'h71, 8'h00);
    check("data", r.rdata, 8'h3C);
    acc(1'b0, BRF_MODE_DIRECT, 8'h7F, 8'h00);
    check("data", r.rdata, 8'hC3);
  endtask

  // group E refused direct, open to working and indirect
  task automatic t_group_e;
    acc(1'b1, BRF_MODE_DIRECT, 8'hE5, 8'h11);
    check("refused", r.refused, 1'b1);
    acc(1'b1, BRF_MODE_DIRECT, 8'hFD, 8'hE0);
    acc(1'b1, BRF_MODE_WORKING, 8'h05, 8'h66);
    check("refused", r.refused, 1'b0);
    acc(1'b0, BRF_MODE_DIRECT, 8'hE5, 8'h00);
    check("refused", r.refused, 1'b1);
    check("data", r.rdata, 8'h00);
    acc(1'b0, BRF_MODE_INDIRECT, 8'hE5, 8'h00);
    check("data", r.rdata, 8'h66);
  endtask

  // byte 12 lies past the vector area and must be ignored
  task automatic t_vectors;
    for (int i = 0; i < 13; i++) begin
      @(negedge clk);
      vec_byte_load = 1'b1;
      vec_byte_addr = 4'(i);
      vec_byte_in = 8'h10 + 8'(i);
    end
    @(negedge clk);
    vec_byte_load = 1'b0;
    for (int k = 0; k < 8; k++) begin
      vec_index = 3'(k);
      @(negedge clk);
      check("vector", vec_out, k < 6 ? {8'h10 + 8'(2 * k), 8'h11 + 8'(2 * k)} : 16'h0);
    end
  endtask

  task automatic finish_test;
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog: the tests need under a hundred cycles
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end

  initial begin
    resetn = 1'b0;
    vec_index = 3'h0;
    vec_byte_in = 8'h00;
    vec_byte_load = 1'b0;
    vec_byte_addr = 4'h0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_decode();
    t_pointer();
    t_group_e();
    t_vectors();
    finish_test();
  end
endmodule
